// [include/irqpm_pkg.sv]
// constants and types shared by the pending/mask bank
package irqpm_pkg;

    localparam int MAX_INST     = 2;
    localparam int NUM_SRC      = 64;
    localparam int DATA_W       = 32;
    localparam int ADDR_W_MIN   = 12;

    // controller_base_address of instance 0 and the spacing between instances
    localparam logic [11:0] CTRL_BASE   = 12'h000;
    localparam logic [11:0] INST_STRIDE = 12'h100;

    // per-instance offsets relative to the controller_base_address
    localparam logic [3:0]  OFF_PEND_HI = 4'h0;
    localparam logic [3:0]  OFF_PEND_LO = 4'h4;
    localparam logic [3:0]  OFF_MASK_HI = 4'h8;
    localparam logic [3:0]  OFF_MASK_LO = 4'hc;

    // block-level interrupt status and enable registers
    localparam logic [11:0] OFF_IRQ_STAT = 12'h200;
    localparam logic [11:0] OFF_IRQ_EN   = 12'h204;

    // global_disable_all position inside mask_low_word
    localparam int MASK_ALL_BIT = 0;

    localparam logic [63:0] PEND_RST = 64'h0;
    localparam logic [63:0] MASK_RST = 64'hffff_ffff_ffff_ffff;
    localparam logic [3:0]  STAT_RST = 4'h0;
    localparam logic [3:0]  IREN_RST = 4'h0;

    // event bits: spurious ack per instance, mask-all write per instance
    localparam int EV_W        = 4;
    localparam int EV_SPUR_LSB = 0;
    localparam int EV_MALL_LSB = 2;

    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_DECERR = 2'h3;

    typedef enum logic [2:0] {
        REG_PEND_HI = 3'h0,
        REG_PEND_LO = 3'h1,
        REG_MASK_HI = 3'h2,
        REG_MASK_LO = 3'h3,
        REG_STAT    = 3'h4,
        REG_IREN    = 3'h5,
        REG_NONE    = 3'h7
    } irqpm_reg_e;

    typedef struct packed {
        logic       hit;
        logic       inst;
        irqpm_reg_e code;
    } irqpm_dec_s;

endpackage : irqpm_pkg

// [rtl/irqpm_bank.sv]
// pending and mask bit maps of the request controller instances
//
// Contract
// R1 - two identical instances, 0 and 1, each with own pending/mask words
// R2 - one pending bit per source: 1 while requesting, 0 otherwise
// R3 - pending bits reload from request levels every clock, no latching
// R4 - pending bits show raw source state regardless of mask
// R5 - reset clears all pending bits
// R6 - pending words read-only; writes discarded
// R7 - bit 0 of low pending word always reads zero
// R8 - low words map sources onto bits 31 down to 1
// R9 - mask bit 1 disables a source, 0 enables it
// R10 - forward request only while pending set and mask clear
// R11 - reset sets every mask bit to one
// R12 - both mask words readable and writable by software
// R13 - writing bit 0 of low mask sets all 63 other mask bits
// R14 - acknowledging a withdrawn request answers spurious
// R15 - software raises cpu_priority_mask before masking levels 1 to 6
// R16 - software avoids masking level 7 sources through the mask words
// R17 - each instance decodes its words relative to its own base
// R18 - high and low words form one 64-bit vector per register pair
//
// Local design decisions: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns
`default_nettype none

module irqpm_bank
    import irqpm_pkg::*;
#(
    parameter int NUM_INST = 2,
    parameter int ADDR_W   = 12
) (
    input  wire logic                                 core_clk_i,
    input  wire logic                                 resetn_i,
    input  wire logic                                 ce_i,
    // AXI4-Lite slave
    input  wire logic [ADDR_W-1:0]                    s_axi_awaddr_i,
    input  wire logic                                 s_axi_awvalid_i,
    output logic                                      s_axi_awready_o,
    input  wire logic [DATA_W-1:0]                    s_axi_wdata_i,
    input  wire logic [DATA_W/8-1:0]                  s_axi_wstrb_i,
    input  wire logic                                 s_axi_wvalid_i,
    output logic                                      s_axi_wready_o,
    output logic [1:0]                                s_axi_bresp_o,
    output logic                                      s_axi_bvalid_o,
    input  wire logic                                 s_axi_bready_i,
    input  wire logic [ADDR_W-1:0]                    s_axi_araddr_i,
    input  wire logic                                 s_axi_arvalid_i,
    output logic                                      s_axi_arready_o,
    output logic [DATA_W-1:0]                         s_axi_rdata_o,
    output logic [1:0]                                s_axi_rresp_o,
    output logic                                      s_axi_rvalid_o,
    input  wire logic                                 s_axi_rready_i,
    // peripheral request levels, bit 0 of each vector unused
    input  wire logic [NUM_INST-1:0][NUM_SRC-1:0]     src_req_i,
    // unmasked requests toward prioritisation
    output logic      [NUM_INST-1:0][NUM_SRC-1:0]     fwd_req_o,
    // acknowledge of a previously accepted source
    input  wire logic                                 ack_req_i,
    input  wire logic                                 ack_inst_i,
    input  wire logic [5:0]                           ack_src_i,
    output logic                                      ack_done_o,
    output logic                                      ack_spurious_o,
    output logic [5:0]                                ack_src_o,
    output logic                                      irq_o
);

    if (NUM_INST < 1 || NUM_INST > MAX_INST) begin : g_chk_inst
        $error("NUM_INST must be 1 or 2");
    end
    if (ADDR_W < ADDR_W_MIN) begin : g_chk_addr
        $error("ADDR_W too small for the register map");
    end

    typedef struct packed {
        logic [NUM_INST-1:0][NUM_SRC-1:0] pend;
        logic [NUM_INST-1:0][NUM_SRC-1:0] mask;
        logic [NUM_INST-1:0][NUM_SRC-1:0] fwd;
        logic                             awready;
        logic                             aw_full;
        logic [ADDR_W-1:0]                aw_addr;
        logic                             wready;
        logic                             w_full;
        logic [DATA_W-1:0]                w_data;
        logic [DATA_W/8-1:0]              w_strb;
        logic                             bvalid;
        logic [1:0]                       bresp;
        logic                             arready;
        logic                             rvalid;
        logic [DATA_W-1:0]                rdata;
        logic [1:0]                       rresp;
        logic [EV_W-1:0]                  irq_stat;
        logic [EV_W-1:0]                  irq_en;
        logic                             irq;
        logic                             ack_done;
        logic                             ack_spur;
        logic [5:0]                       ack_src;
    } irqpm_state_s;

    irqpm_state_s state_r;
    irqpm_state_s state_nxt;

    function automatic irqpm_dec_s decode(input logic [ADDR_W-1:0] a);
        irqpm_dec_s        d;
        logic [ADDR_W-1:0] base;
        d    = '{hit: 1'b0, inst: 1'b0, code: REG_NONE};
        base = '0;
        if (a == ADDR_W'(OFF_IRQ_STAT)) begin
            d = '{hit: 1'b1, inst: 1'b0, code: REG_STAT};
        end else if (a == ADDR_W'(OFF_IRQ_EN)) begin
            d = '{hit: 1'b1, inst: 1'b0, code: REG_IREN};
        end else begin
            for (int i = 0; i < NUM_INST; i++) begin
                // each instance answers only inside its own window [R17]
                base = ADDR_W'(CTRL_BASE)
                     + ADDR_W'(i) * ADDR_W'(INST_STRIDE);
                if (a[ADDR_W-1:4] == base[ADDR_W-1:4]) begin
                    d.inst = 1'(i);
                    d.hit  = 1'b1;
                    if (a[3:0] == OFF_PEND_HI) begin
                        d.code = REG_PEND_HI;
                    end else if (a[3:0] == OFF_PEND_LO) begin
                        d.code = REG_PEND_LO;
                    end else if (a[3:0] == OFF_MASK_HI) begin
                        d.code = REG_MASK_HI;
                    end else if (a[3:0] == OFF_MASK_LO) begin
                        d.code = REG_MASK_LO;
                    end else begin
                        d.hit  = 1'b0;
                    end
                end
            end
        end
        return d;
    endfunction : decode

    function automatic logic [DATA_W-1:0] merge(
        input logic [DATA_W-1:0]   old_v,
        input logic [DATA_W-1:0]   new_v,
        input logic [DATA_W/8-1:0] strb
    );
        logic [DATA_W-1:0] m;
        m = old_v;
        for (int b = 0; b < DATA_W/8; b++) begin
            if (strb[b]) begin
                m[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return m;
    endfunction : merge

    always_comb begin
        irqpm_dec_s        wd;
        irqpm_dec_s        rd;
        logic [EV_W-1:0]   ev;
        logic [DATA_W-1:0] wv;
        logic [DATA_W-1:0] clr;
        wd        = decode(state_r.aw_addr);
        rd        = decode(s_axi_araddr_i);
        ev        = '0;
        wv        = '0;
        clr       = '0;
        state_nxt = state_r;

        // raw levels, bit 0 has no source behind it [R2] [R3] [R4] [R7] [R8]
        for (int i = 0; i < NUM_INST; i++) begin
            state_nxt.pend[i] = {src_req_i[i][NUM_SRC-1:1], 1'b0};
        end

        if (state_r.bvalid && s_axi_bready_i) begin
            state_nxt.bvalid = 1'b0;
        end
        if (state_r.rvalid && s_axi_rready_i) begin
            state_nxt.rvalid = 1'b0;
        end
        if (s_axi_awvalid_i && state_r.awready) begin
            state_nxt.aw_full = 1'b1;
            state_nxt.aw_addr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && state_r.wready) begin
            state_nxt.w_full = 1'b1;
            state_nxt.w_data = s_axi_wdata_i;
            state_nxt.w_strb = s_axi_wstrb_i;
        end

        // write executes once address and data are both held
        if (state_r.aw_full && state_r.w_full && !state_r.bvalid) begin
            state_nxt.aw_full = 1'b0;
            state_nxt.w_full  = 1'b0;
            state_nxt.bvalid  = 1'b1;
            state_nxt.bresp   = wd.hit ? RESP_OKAY : RESP_DECERR;
            if (wd.hit) begin
                case (wd.code)
                    REG_MASK_HI: begin
                        wv = merge(state_r.mask[wd.inst][63:32],
                                   state_r.w_data, state_r.w_strb);
                        state_nxt.mask[wd.inst][63:32] = wv; // [R12] [R18]
                    end
                    REG_MASK_LO: begin
                        wv = merge(state_r.mask[wd.inst][31:0],
                                   state_r.w_data, state_r.w_strb);
                        state_nxt.mask[wd.inst][31:0] = wv; // [R12] [R8]
                        if (wv[MASK_ALL_BIT] && state_r.w_strb[0]
                            && state_r.w_data[MASK_ALL_BIT]) begin
                            state_nxt.mask[wd.inst] = MASK_RST; // [R13]
                            ev[EV_MALL_LSB + int'(wd.inst)] = 1'b1;
                        end
                    end
                    REG_STAT: begin
                        clr = merge('0, state_r.w_data, state_r.w_strb);
                        state_nxt.irq_stat = state_r.irq_stat
                                           & ~clr[EV_W-1:0];
                    end
                    REG_IREN: begin
                        wv = merge({{(DATA_W-EV_W){1'b0}}, state_r.irq_en},
                                   state_r.w_data, state_r.w_strb);
                        state_nxt.irq_en = wv[EV_W-1:0];
                    end
                    // pending words take the write as a no-op [R6]
                    default: begin
                    end
                endcase
            end
        end

        if (s_axi_arvalid_i && state_r.arready) begin
            state_nxt.rvalid = 1'b1;
            state_nxt.rresp  = rd.hit ? RESP_OKAY : RESP_DECERR;
            state_nxt.rdata  = '0;
            if (rd.hit) begin
                case (rd.code)
                    REG_PEND_HI: state_nxt.rdata = state_r.pend[rd.inst][63:32];
                    REG_PEND_LO: state_nxt.rdata = state_r.pend[rd.inst][31:0];
                    REG_MASK_HI: state_nxt.rdata = state_r.mask[rd.inst][63:32];
                    REG_MASK_LO: state_nxt.rdata = state_r.mask[rd.inst][31:0];
                    REG_STAT: state_nxt.rdata = DATA_W'(state_r.irq_stat);
                    REG_IREN: state_nxt.rdata = DATA_W'(state_r.irq_en);
                    default:  state_nxt.rdata = '0;
                endcase
            end
        end

        // one write and one read in flight; ready drops while held
        state_nxt.awready = !state_nxt.aw_full && !state_nxt.bvalid;
        state_nxt.wready  = !state_nxt.w_full && !state_nxt.bvalid;
        state_nxt.arready = !state_nxt.rvalid;

        // a request withdrawn since acceptance has no source left [R14]
        state_nxt.ack_done = ack_req_i;
        if (ack_req_i) begin
            if (int'(ack_inst_i) < NUM_INST
                && state_r.fwd[ack_inst_i][ack_src_i]) begin
                state_nxt.ack_spur = 1'b0;
                state_nxt.ack_src  = ack_src_i;
            end else begin
                state_nxt.ack_spur = 1'b1;
                state_nxt.ack_src  = 6'h0;
                ev[EV_SPUR_LSB + int'(ack_inst_i)] = 1'b1;
            end
        end

        // clear applied above, so a same-cycle event survives it
        state_nxt.irq_stat = state_nxt.irq_stat | ev;

        // mask 1 blocks, 0 passes [R9] [R10] [R18]
        for (int i = 0; i < NUM_INST; i++) begin
            state_nxt.fwd[i] = state_nxt.pend[i] & ~state_nxt.mask[i];
        end
        state_nxt.irq = |(state_nxt.irq_stat & state_nxt.irq_en);

        if (!resetn_i) begin
            state_nxt          = '0;
            state_nxt.awready  = 1'b1;
            state_nxt.wready   = 1'b1;
            state_nxt.arready  = 1'b1;
            state_nxt.irq_stat = STAT_RST;
            state_nxt.irq_en   = IREN_RST;
            for (int i = 0; i < NUM_INST; i++) begin
                state_nxt.pend[i] = PEND_RST; // [R5]
                state_nxt.mask[i] = MASK_RST; // [R11]
            end
        end
    end

    // per-instance copies live in the packed arrays above [R1]
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i || ce_i) begin
            state_r <= state_nxt;
        end
    end

    assign s_axi_awready_o = state_r.awready;
    assign s_axi_wready_o  = state_r.wready;
    assign s_axi_bvalid_o  = state_r.bvalid;
    assign s_axi_bresp_o   = state_r.bresp;
    assign s_axi_arready_o = state_r.arready;
    assign s_axi_rvalid_o  = state_r.rvalid;
    assign s_axi_rdata_o   = state_r.rdata;
    assign s_axi_rresp_o   = state_r.rresp;
    assign fwd_req_o       = state_r.fwd;
    assign ack_done_o      = state_r.ack_done;
    assign ack_spurious_o  = state_r.ack_spur;
    assign ack_src_o       = state_r.ack_src;
    assign irq_o           = state_r.irq;

endmodule : irqpm_bank

`default_nettype wire

// [test/irqpm_bank_assertions.sv]
// concurrent checks on the pending/mask bank ports
`timescale 1ns/1ns
`default_nettype none
module irqpm_bank_assertions
    import irqpm_pkg::*;
#(
    parameter int NUM_INST = 2,
    parameter int ADDR_W   = 12
) (
    input wire logic                             core_clk_i,
    input wire logic                             resetn_i,
    input wire logic                             ce_i,
    input wire logic [ADDR_W-1:0]                s_axi_araddr_i,
    input wire logic                             s_axi_arvalid_i,
    input wire logic                             s_axi_arready_o,
    input wire logic [DATA_W-1:0]                s_axi_rdata_o,
    input wire logic [1:0]                       s_axi_rresp_o,
    input wire logic                             s_axi_rvalid_o,
    input wire logic [NUM_INST-1:0][NUM_SRC-1:0] src_req_i,
    input wire logic [NUM_INST-1:0][NUM_SRC-1:0] fwd_req_o,
    input wire logic                             ack_req_i,
    input wire logic                             ack_inst_i,
    input wire logic [5:0]                       ack_src_i,
    input wire logic                             ack_done_o,
    input wire logic                             ack_spurious_o,
    input wire logic [5:0]                       ack_src_o
);
    logic [11:0] ar_q;
    logic        ack_fwd;
    assign ack_fwd = fwd_req_o[ack_inst_i][ack_src_i];
    // read data is judged by the address it answers
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            ar_q <= 12'h000;
        end else if (s_axi_arvalid_i && s_axi_arready_o) begin
            ar_q <= s_axi_araddr_i[11:0];
        end
    end
    function automatic logic mapped(input logic [11:0] a);
        return (a[11:9] == 3'h0 && a[7:4] == 4'h0) || a[11:3] == 9'h040;
    endfunction : mapped
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    fwd_bit0_a: assert property (
        (fwd_req_o[0][0] | fwd_req_o[NUM_INST-1][0]) == 1'b0)
        else $error("request forwarded on bit 0");
    fwd_src_a: assert property (
        $past(resetn_i) && $past(ce_i)
        |-> (fwd_req_o & ~$past(src_req_i)) == '0)
        else $error("forward without a pending source");
    rst_clear_a: assert property (
        !$past(resetn_i) |-> fwd_req_o == '0 && !s_axi_rvalid_o)
        else $error("state not cleared by reset");
    pend_rd_a: assert property (
        $rose(s_axi_rvalid_o) && ar_q[11:2] == 10'h001
        && $past(src_req_i[0], 1) == $past(src_req_i[0], 2)
        |-> s_axi_rdata_o == ($past(src_req_i[0][31:0]) & 32'hffff_fffe))
        else $error("low pending word differs from sources");
    unmap_rd_a: assert property (
        s_axi_rvalid_o && !mapped(ar_q)
        |-> s_axi_rresp_o == RESP_DECERR && s_axi_rdata_o == '0)
        else $error("unmapped read not refused");
    ack_spur_a: assert property (
        ack_req_i |=> ack_done_o && ack_spurious_o == !$past(ack_fwd))
        else $error("wrong spurious verdict");
    ack_src_a: assert property (
        ack_done_o |-> ack_src_o == (ack_spurious_o ? 6'h0 : $past(ack_src_i)))
        else $error("wrong acknowledged source");
    ack_done_a: assert property (ack_done_o |-> $past(ack_req_i))
        else $error("acknowledge answer without request");
    cover property (ack_done_o && ack_spurious_o);
    cover property (ack_done_o && !ack_spurious_o);
    cover property (s_axi_rvalid_o && s_axi_rresp_o == RESP_DECERR);
endmodule : irqpm_bank_assertions
bind irqpm_bank irqpm_bank_assertions #(.NUM_INST(NUM_INST), .ADDR_W(ADDR_W))
    u_irqpm_bank_assertions (.*);
`default_nettype wire

// [test/irqpm_peer.sv]
// request sources and cpu acknowledge side facing the bank
`timescale 1ns/1ns
`default_nettype none
module irqpm_peer
    import irqpm_pkg::*;
#(
    parameter int NUM_INST = 2
) (
    input  wire logic                             clk_i,
    input  wire logic [NUM_INST-1:0][NUM_SRC-1:0] level_i,
    input  wire logic                             ack_go_i,
    input  wire logic                             ack_inst_i,
    input  wire logic [5:0]                       ack_src_i,
    output var  logic [NUM_INST-1:0][NUM_SRC-1:0] src_req_o,
    output var  logic                             ack_req_o,
    output var  logic                             ack_inst_o,
    output var  logic [5:0]                       ack_src_o
);
    initial begin
        src_req_o = '0;
        {ack_req_o, ack_inst_o, ack_src_o} = '0;
    end
    always @(posedge clk_i) begin
        src_req_o <= level_i;
        // bit 0 has no source; held high so any leak shows
        for (int i = 0; i < NUM_INST; i++) begin
            src_req_o[i][0] <= 1'b1;
        end
        ack_req_o <= ack_go_i;
        // idle select lines toggle, a stale value is never trusted
        ack_inst_o <= ack_go_i ? ack_inst_i : ~ack_inst_o;
        ack_src_o  <= ack_go_i ? ack_src_i : ~ack_src_o;
    end
endmodule : irqpm_peer
`default_nettype wire

// [test/irq_pending_mask_bank_test.sv]
// bench driving the bank over its register bus and request lines
`timescale 1ns/1ns
`default_nettype none
module irq_pending_mask_bank_test
    import irqpm_pkg::*;
;
    localparam logic [1:0][63:0] PAT = {64'h0f0f_a5a5_8765_4321,
                                        64'ha5a5_0f0f_1234_5679};
    logic             core_clk_i, resetn_i, ce_i, go, go_inst;
    logic             s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i;
    logic             s_axi_wready_o, s_axi_bvalid_o, s_axi_bready_i;
    logic             s_axi_arvalid_i, s_axi_arready_o;
    logic             s_axi_rvalid_o, s_axi_rready_i;
    logic [11:0]      s_axi_awaddr_i, s_axi_araddr_i;
    logic [31:0]      s_axi_wdata_i, s_axi_rdata_o;
    logic [3:0]       s_axi_wstrb_i;
    logic [1:0]       s_axi_bresp_o, s_axi_rresp_o;
    logic [1:0][63:0] src_req_i, fwd_req_o, level;
    logic             ack_req_i, ack_inst_i, ack_done_o, ack_spurious_o;
    logic             irq_o;
    logic [5:0]       ack_src_i, ack_src_o, go_src;
    int               err_count = 0;
    int               n_tests = 0;

    irqpm_bank #(.NUM_INST(2), .ADDR_W(12)) u_irqpm_bank (.*);
    irqpm_peer #(.NUM_INST(2)) u_irqpm_peer (.clk_i(core_clk_i),
        .level_i(level), .ack_go_i(go), .ack_inst_i(go_inst),
        .ack_src_i(go_src), .src_req_o(src_req_i), .ack_req_o(ack_req_i),
        .ack_inst_o(ack_inst_i), .ack_src_o(ack_src_i));

    initial begin
        core_clk_i = 1'b0;
        forever #4 core_clk_i = ~core_clk_i;
    end
    task automatic check(input string nm, input logic [127:0] seen, ex);
        n_tests++;
        if (seen !== ex) begin
            err_count++;
            $display("MISMATCH %s expected %0h seen %0h", nm, ex, seen);
        end
    endtask : check
    function automatic logic [11:0] adr(input logic i, input logic [3:0] o);
        return (i ? INST_STRIDE : CTRL_BASE) + {8'h00, o};
    endfunction : adr
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [1:0] er = RESP_OKAY);
        logic aw, w, b;
        @(posedge core_clk_i);
        {aw, w} = 2'b11;
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= d;
        {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= 3'b111;
        do begin
            @(posedge core_clk_i);
            if (aw && s_axi_awready_o === 1'b1) begin
                aw = 1'b0;
                s_axi_awvalid_i <= 1'b0;
            end
            if (w && s_axi_wready_o === 1'b1) begin
                w = 1'b0;
                s_axi_wvalid_i <= 1'b0;
            end
            b = s_axi_bvalid_o;
        end while (b !== 1'b1);
        s_axi_bready_i <= 1'b0;
        check("bresp", s_axi_bresp_o, er);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] ex,
                      input logic [1:0] er = RESP_OKAY);
        logic r;
        @(posedge core_clk_i);
        s_axi_araddr_i <= a;
        {s_axi_arvalid_i, s_axi_rready_i} <= 2'b11;
        do begin
            @(posedge core_clk_i);
            if (s_axi_arready_o === 1'b1) s_axi_arvalid_i <= 1'b0;
            r = s_axi_rvalid_o;
        end while (r !== 1'b1);
        s_axi_rready_i <= 1'b0;
        check("rdata", s_axi_rdata_o, ex);
        check("rresp", s_axi_rresp_o, er);
    endtask : rd
    task automatic do_ack(input logic i, input logic [5:0] s, input logic sp);
        @(posedge core_clk_i);
        {go, go_inst, go_src} <= {1'b1, i, s};
        @(posedge core_clk_i);
        go <= 1'b0;
        repeat (4) begin
            @(posedge core_clk_i);
            if (ack_done_o === 1'b1) break;
        end
        check("ack_done", ack_done_o, 1'b1);
        check("ack_spurious", ack_spurious_o, sp);
        check("ack_src", ack_src_o, sp ? 6'h0 : s);
    endtask : do_ack
    task automatic irq_is(input logic ex);
        repeat (3) @(posedge core_clk_i);
        check("irq", irq_o, ex);
    endtask : irq_is
    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : results
    // whole sequence needs a few hundred cycles at most
    initial begin
        #100000;
        err_count++;
        results();
    end
    initial begin
        {resetn_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} = '0;
        {s_axi_arvalid_i, s_axi_rready_i, go, go_inst, go_src} = '0;
        {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} = '0;
        {ce_i, s_axi_wstrb_i} = 5'h1f;
        level = '0;
        repeat (8) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            rd(adr(i[0], OFF_PEND_HI), 32'h0);
            rd(adr(i[0], OFF_PEND_LO), 32'h0);
            rd(adr(i[0], OFF_MASK_HI), 32'hffff_ffff);
            rd(adr(i[0], OFF_MASK_LO), 32'hffff_ffff);
        end
        $display("test reset values done");
        level <= PAT;
        // peer register plus pending register: two edges before a read
        repeat (2) @(posedge core_clk_i);
        for (int i = 0; i < 2; i++) begin
            rd(adr(i[0], OFF_PEND_HI), PAT[i][63:32]);
            rd(adr(i[0], OFF_PEND_LO), PAT[i][31:0] & ~32'h1);
        end
        check("fwd", fwd_req_o, '0);
        wr(adr(1'b0, OFF_PEND_LO), 32'hffff_ffff);
        rd(adr(1'b0, OFF_PEND_LO), PAT[0][31:0] & ~32'h1);
        level <= '0;
        repeat (2) @(posedge core_clk_i);
        rd(adr(1'b0, OFF_PEND_HI), 32'h0);
        level <= PAT;
        $display("test pending done");
        wr(adr(1'b0, OFF_MASK_HI), 32'h0000_ffff);
        wr(adr(1'b0, OFF_MASK_LO), 32'hffff_000e);
        wr(adr(1'b1, OFF_MASK_HI), 32'h0);
        wr(adr(1'b1, OFF_MASK_LO), 32'h0);
        rd(adr(1'b0, OFF_MASK_HI), 32'h0000_ffff);
        rd(adr(1'b0, OFF_MASK_LO), 32'hffff_000e);
        check("fwd0", fwd_req_o[0], PAT[0] & 64'hffff_0000_0000_fff0);
        check("fwd1", fwd_req_o[1], PAT[1] & ~64'h1);
        // clock enable low freezes the pending map against the sources
        ce_i <= 1'b0;
        level <= '0;
        repeat (3) @(posedge core_clk_i);
        check("ce hold", fwd_req_o[1], PAT[1] & ~64'h1);
        ce_i <= 1'b1;
        level <= PAT;
        repeat (2) @(posedge core_clk_i);
        $display("test clock enable done");
        do_ack(1'b0, 6'd4, 1'b0);
        do_ack(1'b0, 6'd63, 1'b0);
        // source 4 masked while still requesting, so its ack answers spurious
        wr(adr(1'b0, OFF_MASK_LO), 32'hffff_001e);
        do_ack(1'b0, 6'd4, 1'b1);
        do_ack(1'b1, 6'd0, 1'b1);
        rd(OFF_IRQ_STAT, 32'h3);
        irq_is(1'b0);
        wr(OFF_IRQ_EN, 32'h1);
        irq_is(1'b1);
        wr(OFF_IRQ_STAT, 32'h1);
        irq_is(1'b0);
        $display("test acknowledge done");
        // no level-7 source sits behind these words
        wr(adr(1'b0, OFF_MASK_LO), 32'h1);
        rd(adr(1'b0, OFF_MASK_HI), 32'hffff_ffff);
        rd(adr(1'b0, OFF_MASK_LO), 32'hffff_ffff);
        rd(adr(1'b1, OFF_MASK_LO), 32'h0);
        check("fwd all", fwd_req_o[0], 64'h0);
        rd(OFF_IRQ_STAT, 32'h6);
        rd(12'h010, 32'h0, RESP_DECERR);
        rd(12'h300, 32'h0, RESP_DECERR);
        wr(12'h110, 32'h0, RESP_DECERR);
        $display("test mask all done");
        results();
    end
endmodule : irq_pending_mask_bank_test
`default_nettype wire
